// ---- design/nco_pkg.sv ----
package nco_pkg;
  // oscillator geometry
  localparam int ACC_W = 32;
  localparam int N_PHASE = 8;
  localparam int PH_SHIFT = 3;
  localparam int OUT_BIT = 20;
  localparam logic [ACC_W-1:0] JUMP_INIT = 32'h0008_0000;
  localparam logic [ACC_W-1:0] JUMP_MAX = 32'hffff_ffff;
  localparam logic [ACC_W-1:0] JUMP_MIN = 32'h0000_0001;
  localparam logic [ACC_W-1:0] JUMP_STEP = 32'h0000_0001;
  // filter window and decision limits
  localparam int WIN_EXP = 8;
  localparam int MIN_EXP = 4;
  localparam int CNT_W = WIN_EXP + 1;
  localparam logic [CNT_W-1:0] WIN_LAST = 9'h0ff;
  localparam logic [CNT_W-1:0] MIN_TRANS = 9'h010;
  localparam logic [1:0] HOLD_STEPS = 2'h3;
  // request hold, longer than two clock periods
  localparam logic [2:0] REQ_HOLD = 3'h4;
  // quadrant drift codes
  localparam logic [1:0] DRIFT_UP = 2'h1;
  localparam logic [1:0] DRIFT_DOWN = 2'h3;

  typedef enum logic [0:0] {
    NCO_SD_IDLE = 1'b0,
    NCO_SD_ARMED = 1'b1
  } nco_sd_state_t;

  typedef enum logic [0:0] {
    NCO_RQ_IDLE = 1'b0,
    NCO_RQ_HOLD = 1'b1
  } nco_rq_state_t;
endpackage : nco_pkg

// ---- design/nco_flt_if.sv ----
`timescale 1ns/1ps
interface nco_flt_if;
  logic window_end;
  logic trans;
  logic early;
  logic up;
  logic down;
  logic decide;
  modport master (output window_end, output trans, output early,
                  input up, input down, input decide);
  modport slave (input window_end, input trans, input early,
                 output up, output down, output decide);
endinterface : nco_flt_if

// ---- design/nco_accum.sv ----
`timescale 1ns/1ps
module nco_accum
  import nco_pkg::*;
#(
  parameter int accumulator_width = nco_pkg::ACC_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // jump size
  input wire logic [accumulator_width-1:0] jump,
  // accumulators
  output logic [accumulator_width-1:0] acc [nco_pkg::N_PHASE]
);
  import nco_pkg::*;

  logic [accumulator_width-1:0] base_next;
  logic [accumulator_width-1:0] step;

  assign base_next = acc[0] + jump;
  assign step = jump >> PH_SHIFT;

  genvar k;
  generate
    for (k = 0; k < N_PHASE; k++) begin : g_acc
      localparam logic [accumulator_width-1:0] IDX = accumulator_width'(k);
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          acc[k] <= '0;
        end else begin
          acc[k] <= base_next + IDX * step;
        end
      end
    end
  endgenerate
endmodule : nco_accum

// ---- design/nco_flt_slave.sv ----
`timescale 1ns/1ps
module nco_flt_slave
  import nco_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // flags in, decision out
  nco_flt_if.slave flt
);
  import nco_pkg::*;

  logic [CNT_W-1:0] trans_cnt;
  logic [CNT_W-1:0] early_cnt;
  logic [1:0] hold;
  logic up;
  logic down;
  logic decide;
  wire logic enough = trans_cnt >= MIN_TRANS;
  wire logic [CNT_W-1:0] half = trans_cnt >> 1;
  wire logic go_up = enough && (early_cnt > half);
  wire logic [CNT_W-1:0] trans_add = {{(CNT_W-1){1'b0}}, flt.trans};
  wire logic [CNT_W-1:0] early_add = {{(CNT_W-1){1'b0}}, flt.early};

  //////////////////////////////////////////////////////////////////////////
  // window counters, decision at window end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trans_cnt <= '0;
      early_cnt <= '0;
    end else if (flt.window_end) begin
      trans_cnt <= trans_add;
      early_cnt <= early_add;
    end else begin
      trans_cnt <= trans_cnt + trans_add;
      early_cnt <= early_cnt + early_add;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold <= '0;
      up <= 1'b0;
      down <= 1'b0;
      decide <= 1'b0;
    end else begin
      decide <= flt.window_end && enough;
      if (flt.window_end && enough) begin
        hold <= HOLD_STEPS;
        up <= go_up;
        down <= !go_up;
      end else if (hold != 2'h0) begin
        hold <= hold - 2'h1;
      end else begin
        up <= 1'b0;
        down <= 1'b0;
      end
    end
  end

  assign flt.up = up;
  assign flt.down = down;
  assign flt.decide = decide;
endmodule : nco_flt_slave

// ---- design/nco_top.sv ----
// Operation
// - accumulator advances by jump every cycle
// - eight accumulators spaced one eighth jump
// - clock output is one accumulator bit
// - fine frequency set only by jump
// - width parameter sets accumulator bits
// - debug option: fixed jump, gated detector
// - monitor option drives clock differential pair
// - manager raises or lowers jump per request
// - request enable, direction, control held long
// - two bang-bang detectors, in-phase and quadrature
// - upward drift too fast, downward too slow
// - raw flags filtered before quadrant decision
// - quadrant derived, shift detector tracks changes
// - master window two-power length, slaves count
// - at window zero slaves declare direction
// - decide only with enough transitions
// - threshold is half counted transitions
// - filtered outputs held three steps
// - detector flags transition and early clock
// - shift detection armed after first quadrant
`timescale 1ns/1ps
module nco_top
  import nco_pkg::*;
#(
  parameter int accumulator_width = nco_pkg::ACC_W,
  parameter bit clock_monitor_option = 1'b0,
  parameter bit detector_debug_option = 1'b0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // serial stream
  input wire logic serial_data_in,
  // debug controls
  input wire logic detector_enable_in,
  input wire logic [accumulator_width-1:0] fixed_jump_in,
  // recovered clock
  output logic recovered_clk,
  output logic [nco_pkg::N_PHASE-1:0] phase_bits,
  output logic monitor_clock_out_p,
  output logic monitor_clock_out_n,
  // loop status
  output logic [accumulator_width-1:0] jump_size,
  output logic [1:0] quadrant,
  output logic quadrant_valid,
  output logic shifting_en,
  output logic shift_up,
  output logic shift_down
);
  import nco_pkg::*;

  localparam logic [accumulator_width-1:0] QTR_OFS =
    accumulator_width'(1) << (OUT_BIT - 1);

  // maps the quadrant code onto a circular index
  function automatic logic [1:0] quad_index(input logic [1:0] code);
    logic [1:0] idx;
    idx = {code[1], code[1] ^ code[0]};
    return idx;
  endfunction : quad_index

  // bang-bang early decision
  function automatic logic bb_early(input logic prev, input logic mid, input logic cur);
    logic e;
    e = (prev ^ cur) && (mid == prev);
    return e;
  endfunction : bb_early

  //////////////////////////////////////////////////////////////////////////
  // reset release and input synchroniser
  logic rst_s1;
  logic rst_n;
  logic data_s1;
  logic data_s2;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_s1 <= 1'b0;
      data_s2 <= 1'b0;
    end else begin
      data_s1 <= serial_data_in;
      data_s2 <= data_s1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // oscillator
  logic [accumulator_width-1:0] jump;
  logic [accumulator_width-1:0] acc [N_PHASE];
  wire logic [accumulator_width-1:0] jump_eff =
    detector_debug_option ? fixed_jump_in : jump;
  wire logic det_en = detector_debug_option ? detector_enable_in : 1'b1;

  nco_accum #(
    .accumulator_width(accumulator_width)
  ) u_accum (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .jump(jump_eff),
    .acc(acc)
  );

  logic [N_PHASE-1:0] ph;
  logic clk_q;

  genvar k;
  generate
    for (k = 0; k < N_PHASE; k++) begin : g_ph
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          ph[k] <= 1'b0;
        end else begin
          ph[k] <= acc[k][OUT_BIT];
        end
      end
    end
  endgenerate

  wire logic [accumulator_width-1:0] acc_q = acc[0] + QTR_OFS;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= acc_q[OUT_BIT];
    end
  end

  assign phase_bits = ph;
  assign recovered_clk = ph[0];
  assign monitor_clock_out_p = clock_monitor_option ? ph[0] : 1'b0;
  assign monitor_clock_out_n = clock_monitor_option ? ~ph[0] : 1'b0;

  //////////////////////////////////////////////////////////////////////////
  // bang-bang detectors on in-phase and quadrature clocks
  nco_flt_if flt_i ();
  nco_flt_if flt_q ();
  logic [1:0] clk_lvl;
  logic [1:0] clk_prev;
  logic [1:0] smp_cur;
  logic [1:0] smp_prev;
  logic [1:0] smp_mid;
  logic [1:0] det_stb;
  logic [1:0] trans_p;
  logic [1:0] early_p;

  assign clk_lvl = {clk_q, ph[0]};

  generate
    for (k = 0; k < 2; k++) begin : g_bb
      wire logic fall = clk_prev[k] && !clk_lvl[k];
      wire logic rise = !clk_prev[k] && clk_lvl[k];
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          clk_prev[k] <= 1'b0;
          smp_cur[k] <= 1'b0;
          smp_prev[k] <= 1'b0;
          smp_mid[k] <= 1'b0;
          det_stb[k] <= 1'b0;
        end else begin
          clk_prev[k] <= clk_lvl[k];
          det_stb[k] <= fall && det_en;
          if (rise) begin
            smp_mid[k] <= data_s2;
          end
          if (fall) begin
            smp_prev[k] <= smp_cur[k];
            smp_cur[k] <= data_s2;
          end
        end
      end
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          trans_p[k] <= 1'b0;
          early_p[k] <= 1'b0;
        end else begin
          trans_p[k] <= det_stb[k] && (smp_prev[k] ^ smp_cur[k]);
          early_p[k] <= det_stb[k] && bb_early(smp_prev[k], smp_mid[k], smp_cur[k]);
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // filter master window
  logic [CNT_W-1:0] win_cnt;
  wire logic win_end = det_en && (win_cnt == '0);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt <= WIN_LAST;
    end else if (!det_en || win_end) begin
      win_cnt <= WIN_LAST;
    end else begin
      win_cnt <= win_cnt - 9'h001;
    end
  end

  assign flt_i.window_end = win_end;
  assign flt_q.window_end = win_end;
  assign flt_i.trans = trans_p[0];
  assign flt_i.early = early_p[0];
  assign flt_q.trans = trans_p[1];
  assign flt_q.early = early_p[1];

  nco_flt_slave u_slave_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .flt(flt_i)
  );

  nco_flt_slave u_slave_q (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .flt(flt_q)
  );

  //////////////////////////////////////////////////////////////////////////
  // quadrant detector
  logic i_early;
  logic q_early;
  logic i_known;
  logic q_known;
  logic quad_new;
  wire logic both_known = i_known && q_known;
  wire logic [1:0] quad_code = {i_early, q_early};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      i_early <= 1'b0;
      q_early <= 1'b0;
      i_known <= 1'b0;
      q_known <= 1'b0;
      quad_new <= 1'b0;
    end else if (!det_en) begin
      i_known <= 1'b0;
      q_known <= 1'b0;
      quad_new <= 1'b0;
    end else begin
      quad_new <= flt_i.decide || flt_q.decide;
      if (flt_i.decide) begin
        i_early <= flt_i.up;
        i_known <= 1'b1;
      end
      if (flt_q.decide) begin
        q_early <= flt_q.up;
        q_known <= 1'b1;
      end
    end
  end

  assign quadrant = quad_code;
  assign quadrant_valid = both_known;

  //////////////////////////////////////////////////////////////////////////
  // quadrant shift detector
  nco_sd_state_t sd_state;
  nco_sd_state_t next_sd_state;
  logic [1:0] prev_idx;
  logic req_fire;
  logic req_up_dir;
  wire logic [1:0] cur_idx = quad_index(quad_code);
  wire logic [1:0] drift = cur_idx - prev_idx;
  wire logic quad_evt = quad_new && both_known;

  always_comb begin
    next_sd_state = sd_state;
    case (sd_state)
      NCO_SD_IDLE: begin
        if (quad_evt) begin
          next_sd_state = NCO_SD_ARMED;
        end
      end
      NCO_SD_ARMED: begin
        if (!det_en) begin
          next_sd_state = NCO_SD_IDLE;
        end
      end
      default: begin
        next_sd_state = NCO_SD_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sd_state <= NCO_SD_IDLE;
      prev_idx <= 2'h0;
      req_fire <= 1'b0;
      req_up_dir <= 1'b0;
    end else begin
      sd_state <= next_sd_state;
      req_fire <= 1'b0;
      if (quad_evt) begin
        prev_idx <= cur_idx;
      end
      if (quad_evt && sd_state == NCO_SD_ARMED && det_en) begin
        if (drift == DRIFT_UP) begin
          req_fire <= 1'b1;
          req_up_dir <= 1'b0;
        end else if (drift == DRIFT_DOWN) begin
          req_fire <= 1'b1;
          req_up_dir <= 1'b1;
        end
      end
    end
  end

  assign shifting_en = (sd_state == NCO_SD_ARMED);
  assign shift_up = req_fire && !req_up_dir;
  assign shift_down = req_fire && req_up_dir;

  //////////////////////////////////////////////////////////////////////////
  // frequency change request, held for the crossing
  nco_rq_state_t rq_state;
  logic [2:0] rq_cnt;
  logic rq_en;
  logic rq_dir;
  logic rq_ctrl;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rq_state <= NCO_RQ_IDLE;
      rq_cnt <= 3'h0;
      rq_en <= 1'b0;
      rq_dir <= 1'b0;
      rq_ctrl <= 1'b0;
    end else begin
      case (rq_state)
        NCO_RQ_IDLE: begin
          if (req_fire) begin
            rq_state <= NCO_RQ_HOLD;
            rq_cnt <= REQ_HOLD;
            rq_en <= 1'b1;
            rq_dir <= req_up_dir;
            rq_ctrl <= 1'b1;
          end
        end
        NCO_RQ_HOLD: begin
          if (rq_cnt == 3'h0) begin
            rq_state <= NCO_RQ_IDLE;
            rq_en <= 1'b0;
            rq_ctrl <= 1'b0;
          end else begin
            rq_cnt <= rq_cnt - 3'h1;
          end
        end
        default: begin
          rq_state <= NCO_RQ_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // frequency manager
  logic [2:0] ctrl_s;
  logic [1:0] en_s;
  logic [1:0] dir_s;
  wire logic take = ctrl_s[1] && !ctrl_s[2] && en_s[1];
  wire logic at_max = (jump == JUMP_MAX);
  wire logic at_min = (jump == JUMP_MIN);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_s <= 3'h0;
      en_s <= 2'h0;
      dir_s <= 2'h0;
    end else begin
      ctrl_s <= {ctrl_s[1:0], rq_ctrl};
      en_s <= {en_s[0], rq_en};
      dir_s <= {dir_s[0], rq_dir};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      jump <= JUMP_INIT;
    end else if (take && dir_s[1] && !at_max) begin
      jump <= jump + JUMP_STEP;
    end else if (take && !dir_s[1] && !at_min) begin
      jump <= jump - JUMP_STEP;
    end
  end

  assign jump_size = jump_eff;
endmodule : nco_top

// ---- dv/nco_tx_model.sv ----
`timescale 1ns/1ps
module nco_tx_model #(
  parameter realtime BIT_NS = 16.016
) (
  // control
  input wire logic run,
  // serial line
  output logic sdata
);
  logic [6:0] prbs = 7'h7f;
  initial sdata = 1'b0;
  // prbs7 stream: transition rich and balanced, line holds when stopped
  always begin
    #(BIT_NS);
    if (run) begin
      prbs = {prbs[5:0], prbs[6] ^ prbs[5]};
      sdata = prbs[0];
    end
  end
endmodule : nco_tx_model

// ---- dv/nco_top_checker.sv ----
`timescale 1ns/1ps
module nco_top_checker
  import nco_pkg::*;
#(
  parameter int accumulator_width = nco_pkg::ACC_W,
  parameter bit clock_monitor_option = 1'b0,
  parameter bit detector_debug_option = 1'b0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // inputs
  input wire logic serial_data_in,
  input wire logic [accumulator_width-1:0] fixed_jump_in,
  // outputs
  input wire logic recovered_clk,
  input wire logic [nco_pkg::N_PHASE-1:0] phase_bits,
  input wire logic monitor_clock_out_p,
  input wire logic monitor_clock_out_n,
  input wire logic [accumulator_width-1:0] jump_size,
  input wire logic [1:0] quadrant,
  input wire logic quadrant_valid,
  input wire logic shifting_en,
  input wire logic shift_up,
  input wire logic shift_down
);
  localparam logic [accumulator_width-1:0] FULL = accumulator_width'(1) << OUT_BIT;
  logic [2:0] up_cnt;
  logic [9:0] quiet_cnt;
  logic data_d;
  logic settled;
  logic any_shift;
  assign settled = (up_cnt == 3'h7);
  assign any_shift = shift_up || shift_down;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      up_cnt <= 3'h0;
      quiet_cnt <= 10'h000;
      data_d <= 1'b0;
    end else begin
      up_cnt <= settled ? up_cnt : up_cnt + 3'h1;
      quiet_cnt <= (serial_data_in != data_d) ? 10'h000 : quiet_cnt + {9'h000, !(&quiet_cnt)};
      data_d <= serial_data_in;
    end
  end
  function automatic logic [1:0] idx(input logic [1:0] q);
    return {q[1], q[1] ^ q[0]};
  endfunction : idx
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  AST_JUMP_STEP: assert property (settled && !detector_debug_option && jump_size != $past(jump_size)
    |-> jump_size == $past(jump_size) + 1'b1 || jump_size == $past(jump_size) - 1'b1)
    else $error("jump size moved by more than one step");
  AST_JUMP_FIXED: assert property (settled && detector_debug_option
    && $past(fixed_jump_in, 2) == fixed_jump_in && $past(fixed_jump_in) == fixed_jump_in
    |-> jump_size == fixed_jump_in) else $error("jump size differs from fixed value");
  AST_CLK_TOGGLE: assert property (settled && jump_size == FULL && $past(jump_size) == FULL
    && $past(jump_size, 2) == FULL && $past(jump_size, 3) == FULL
    |-> recovered_clk != $past(recovered_clk)) else $error("clock bit did not toggle");
  AST_LANE0: assert property (settled |-> phase_bits[0] == recovered_clk)
    else $error("lane zero differs from recovered clock");
  AST_LANE_SPREAD: assert property (settled && $past(jump_size, 2) < FULL
    |-> $countones(phase_bits[N_PHASE-1:1] ^ phase_bits[N_PHASE-2:0]) <= 1)
    else $error("phase lanes not evenly spread");
  AST_PULSE: assert property (any_shift |-> !(shift_up && shift_down) ##1 !any_shift)
    else $error("shift pulse malformed");
  AST_ARMED: assert property (any_shift |-> shifting_en && quadrant_valid)
    else $error("shift reported while not armed");
  AST_UP_DIR: assert property (shift_up |-> idx(quadrant) == idx($past(quadrant, 3)) + 2'h1)
    else $error("shift up without upward quadrant step");
  AST_DOWN_DIR: assert property (shift_down |-> idx(quadrant) == idx($past(quadrant, 3)) - 2'h1)
    else $error("shift down without downward quadrant step");
  AST_QUIET: assert property (quiet_cnt >= 10'd600 |-> $stable(quadrant) && !any_shift)
    else $error("decision made without data transitions");
  AST_MON_PAIR: assert property (settled |-> (clock_monitor_option ?
    monitor_clock_out_n == !monitor_clock_out_p : !monitor_clock_out_p && !monitor_clock_out_n))
    else $error("monitor pair wrong");
  COV_UP: cover property (shift_up);
  COV_VALID: cover property ($rose(quadrant_valid));
  COV_FULL: cover property (settled && jump_size == FULL);
endmodule : nco_top_checker
bind nco_top nco_top_checker #(
  .accumulator_width(accumulator_width),
  .clock_monitor_option(clock_monitor_option),
  .detector_debug_option(detector_debug_option)
) u_nco_top_checker (
  .sys_clk(sys_clk), .rst_b(rst_b), .serial_data_in(serial_data_in),
  .fixed_jump_in(fixed_jump_in), .recovered_clk(recovered_clk), .phase_bits(phase_bits),
  .monitor_clock_out_p(monitor_clock_out_p), .monitor_clock_out_n(monitor_clock_out_n),
  .jump_size(jump_size), .quadrant(quadrant), .quadrant_valid(quadrant_valid),
  .shifting_en(shifting_en), .shift_up(shift_up), .shift_down(shift_down)
);

// ---- dv/nco_top_bench.sv ----
`timescale 1ns/1ps
module nco_top_bench;
  import nco_pkg::*;
  logic sys_clk;
  logic rst_b = 1'b0;
  logic tx_run = 1'b0;
  logic det_en = 1'b0;
  logic [ACC_W-1:0] fix_jump = JUMP_INIT;
  logic sdata, qv, sh_en, sh_up, sh_dn, dclk, dqv, dclk_prev;
  logic [ACC_W-1:0] jump, djump;
  logic [ACC_W-1:0] jump_prev = JUMP_INIT;
  logic [ACC_W-1:0] djump_prev = JUMP_INIT;
  logic [ACC_W-1:0] jump_model = JUMP_INIT;
  logic [ACC_W-1:0] exp_q [$];
  logic [ACC_W-1:0] dexp_q [$];
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int ups = 0;
  int downs = 0;
  int toggles;
  ////////////////////////////////////////////////////////////////
  nco_tx_model u_nco_tx_model (.run(tx_run), .sdata(sdata));
  nco_top #(.clock_monitor_option(1'b1)) u_nco_top (
    .sys_clk(sys_clk), .rst_b(rst_b), .serial_data_in(sdata),
    .detector_enable_in(det_en), .fixed_jump_in(fix_jump), .recovered_clk(),
    .phase_bits(), .monitor_clock_out_p(), .monitor_clock_out_n(), .jump_size(jump),
    .quadrant(), .quadrant_valid(qv), .shifting_en(sh_en), .shift_up(sh_up),
    .shift_down(sh_dn));
  nco_top #(.detector_debug_option(1'b1)) u_nco_top_dbg (
    .sys_clk(sys_clk), .rst_b(rst_b), .serial_data_in(sdata),
    .detector_enable_in(det_en), .fixed_jump_in(fix_jump), .recovered_clk(dclk),
    .phase_bits(), .monitor_clock_out_p(), .monitor_clock_out_n(), .jump_size(djump),
    .quadrant(), .quadrant_valid(dqv), .shifting_en(), .shift_up(), .shift_down());
  ////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task check(input logic [ACC_W-1:0] got, input logic [ACC_W-1:0] want);
    num_checks++;
    if (got !== want) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask : check
  task wrap_up;
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task done(input string name);
    $display("Test %s finished", name);
  endtask : done
  task set_fixed(input logic [ACC_W-1:0] v);
    @(posedge sys_clk);
    fix_jump <= v;
    dexp_q.push_back(v);
    repeat (4) @(posedge sys_clk);
  endtask : set_fixed
  // timeout
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      wrap_up();
    end
  end
  // note expected jump from each shift pulse
  always @(posedge sys_clk) begin
    if (rst_b && sh_dn === 1'b1) begin
      jump_model = jump_model + JUMP_STEP;
      downs++;
      exp_q.push_back(jump_model);
    end
    if (rst_b && sh_up === 1'b1) begin
      jump_model = jump_model - JUMP_STEP;
      ups++;
      exp_q.push_back(jump_model);
    end
  end
  // compare each jump change with oldest note
  always @(posedge sys_clk) begin
    if (rst_b && jump !== jump_prev) begin
      if (exp_q.size() == 0) check(jump, jump_prev);
      else check(jump, exp_q.pop_front());
    end
    if (rst_b && djump !== djump_prev) begin
      if (dexp_q.size() == 0) check(djump, djump_prev);
      else check(djump, dexp_q.pop_front());
    end
    jump_prev <= jump;
    djump_prev <= djump;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'he77e55f6));
    repeat (5) @(posedge sys_clk);
    check(jump, JUMP_INIT);
    check(ACC_W'(qv), ACC_W'(0));
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (1000) @(posedge sys_clk);
    check(ACC_W'(qv), ACC_W'(0));
    check(jump, JUMP_INIT);
    done("quiet line");
    for (int i = 0; i < 4; i++) set_fixed($urandom());
    set_fixed(ACC_W'(1) << OUT_BIT);
    set_fixed(32'h0004_0000);
    repeat (8) @(posedge sys_clk);
    toggles = 0;
    dclk_prev = dclk;
    repeat (64) begin
      @(posedge sys_clk);
      if (dclk !== dclk_prev) toggles++;
      dclk_prev = dclk;
    end
    check(ACC_W'(toggles), ACC_W'(16));
    set_fixed(JUMP_INIT);
    done("fixed jump");
    tx_run <= 1'b1;
    repeat (1500) @(posedge sys_clk);
    check(ACC_W'(dqv), ACC_W'(0));
    check(ACC_W'(qv), ACC_W'(1));
    det_en <= 1'b1;
    repeat (1500) @(posedge sys_clk);
    check(ACC_W'(dqv), ACC_W'(1));
    done("detector gate");
    repeat (30000) @(posedge sys_clk);
    tx_run <= 1'b0;
    repeat (300) @(posedge sys_clk);
    check(ACC_W'(ups > downs), ACC_W'(1));
    check(jump, jump_model);
    check(ACC_W'(exp_q.size()), ACC_W'(0));
    check(ACC_W'(sh_en), ACC_W'(1));
    done("drift");
    wrap_up();
  end
endmodule : nco_top_bench
